/* verilog/lst_selftest_ctrl.sv */
// Link self-test control: registers, paging, remote config and gating
`default_nettype none
module lst_selftest_ctrl #(
  parameter int W     = 8,                      // Received word width
  parameter int PORTS = 4                       // Receive ports
) (
  input  wire logic             clk_i,          // 40 MHz system clock
  input  wire logic             rst_i,          // Sync reset, active high
  // Local serial-management register access
  input  wire logic             loc_req_i,      // Access request
  input  wire logic             loc_we_i,       // Write when high
  input  wire logic [7:0]       loc_addr_i,     // Register offset
  input  wire logic [7:0]       loc_wdata_i,    // Write data
  output logic      [7:0]       loc_rdata_o,    // Read data
  output logic                  loc_ack_o,      // Access done
  // Control-channel register access
  input  wire logic             cc_req_i,       // Access request
  input  wire logic             cc_we_i,        // Write when high
  input  wire logic [7:0]       cc_addr_i,      // Register offset
  input  wire logic [7:0]       cc_wdata_i,     // Write data
  output logic      [7:0]       cc_rdata_o,     // Read data
  output logic                  cc_ack_o,       // Access done
  // Receive ports
  input  wire logic [PORTS*W-1:0] rx_word_i,    // Received words
  input  wire logic [PORTS-1:0] rx_valid_i,     // Word strobes
  input  wire logic [PORTS-1:0] rx_lock_i,      // Receiver lock
  input  wire logic [PORTS-1:0] remote_selftest_active_i, // Remote status
  // Back-channel remote register write
  output logic                  bc_req_o,       // Write pending
  output logic      [7:0]       bc_addr_o,      // Remote offset
  output logic      [7:0]       bc_data_o,      // Remote data
  input  wire logic             bc_ack_i,       // Write taken
  // Pins and output path
  output logic      [3:0]       gpio_pass_o,    // Routed pass indication
  output logic      [3:0]       gpio_pass_oe_o, // Pin driven by routing
  output logic                  outputs_enable_o, // Device outputs allowed
  output logic                  csi_lp11_idle_o, // CSI-2 held in LP11
  output logic                  pgen_allow_o,   // Pattern gen may drive
  input  wire logic             pgen_run_i,     // Pattern gen started
  output logic                  selftest_active_o // Self-test running
);
  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]       page_ff;                    // Port page select
  logic [7:0]       ctrl_ff;                    // Self-test control
  logic [7:0]       pin_ff [4];                 // Pin function control
  logic [1:0]       clk_sel_ff;                 // Captured clock select
  logic             bc_req_ff;                  // Remote write pending
  logic [7:0]       bc_data_ff;                 // Remote write data
  logic [PORTS-1:0] pass_ff;                    // Per-port pass level
  logic [7:0]       loc_rdata_ff;               // Local read data
  logic [7:0]       cc_rdata_ff;                // Channel read data
  logic             loc_ack_ff;                 // Local ack
  logic             cc_ack_ff;                  // Channel ack
  logic [3:0]       gpio_ff;                    // Pin output level
  logic [3:0]       gpio_oe_ff;                 // Pin output enable

  ////////////////////////////////////////////////////////////////////////
  // Access arbitration: local wins, channel waits one access
  wire       loc_take = loc_req_i & ~loc_ack_ff;
  wire       cc_take  = cc_req_i & ~cc_ack_ff & ~loc_take;
  wire       wr_en    = (loc_take & loc_we_i) | (cc_take & cc_we_i);
  wire [7:0] wr_addr  = loc_take ? loc_addr_i : cc_addr_i;
  wire [7:0] wr_data  = loc_take ? loc_wdata_i : cc_wdata_i;
  wire       active   = ctrl_ff[lst_pkg::CTRL_EN_BIT];
  wire [7:0] nxt_ctrl = wr_data;
  wire       start    = wr_en && wr_addr == lst_pkg::CTRL_ADDR
                      && nxt_ctrl[lst_pkg::CTRL_EN_BIT] && !active;
  wire       stop     = wr_en && wr_addr == lst_pkg::CTRL_ADDR
                      && !nxt_ctrl[lst_pkg::CTRL_EN_BIT] && active;
  wire [1:0] rd_port  = page_ff[lst_pkg::PAGE_RD_LO +: 2];
  wire [1:0] gating   = ctrl_ff[lst_pkg::CTRL_GATE_LO +: 2];
  wire       gate_on  = gating == lst_pkg::GATE_ENABLED;

  ////////////////////////////////////////////////////////////////////////
  // Per-port checkers
  wire  [PORTS-1:0] err;                        // Per-port mismatch
  wire  [7:0]       tally [PORTS];              // Per-port tally
  for (genvar p = 0; p < PORTS; p++) begin : g_port
    lst_port_check #(.W(W)) u_chk (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .start_i  (start),
      .active_i (active),
      .lock_i   (rx_lock_i[p]),
      .valid_i  (rx_valid_i[p]),
      .word_i   (rx_word_i[p*W +: W]),
      .err_o    (err[p]),
      .tally_o  (tally[p])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read decode, shared by both access paths
  function automatic logic [7:0] rd_mux(input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    if (a == lst_pkg::PAGE_SEL_ADDR) begin
      d = page_ff;
    end else if (a == lst_pkg::CTRL_ADDR) begin
      d = ctrl_ff;
    end else if (a == lst_pkg::TALLY_ADDR) begin
      d = tally[rd_port];
    end else if (a == lst_pkg::DEBUG_ADDR) begin
      d[lst_pkg::DEBUG_RACT_BIT] = remote_selftest_active_i[rd_port];
    end else if (a >= lst_pkg::PIN_CTL_ADDR
                 && a < lst_pkg::PIN_CTL_ADDR + 8'(lst_pkg::NUM_PINS)) begin
      d = pin_ff[2'(a - lst_pkg::PIN_CTL_ADDR)];
    end
    return d;
  endfunction : rd_mux

  ////////////////////////////////////////////////////////////////////////
  // Control, page and pin registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      page_ff <= lst_pkg::PAGE_SEL_RST;
      ctrl_ff <= lst_pkg::CTRL_RST;
      for (int i = 0; i < 4; i++) begin
        pin_ff[i] <= lst_pkg::PIN_CTL_RST;
      end
    end else if (wr_en) begin
      if (wr_addr == lst_pkg::PAGE_SEL_ADDR) begin
        page_ff <= wr_data;
      end
      if (wr_addr == lst_pkg::CTRL_ADDR) begin
        ctrl_ff <= nxt_ctrl;
      end
      for (int i = 0; i < 4; i++) begin
        if (wr_addr == lst_pkg::PIN_CTL_ADDR + 8'(i)) begin
          pin_ff[i] <= wr_data;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Clock select capture and remote configuration write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clk_sel_ff <= 2'h0;
      bc_req_ff  <= 1'b0;
      bc_data_ff <= 8'h00;
    end else if (start) begin
      clk_sel_ff <= nxt_ctrl[lst_pkg::CTRL_CLK_LO +: 2];
      bc_req_ff  <= 1'b1;
      bc_data_ff <= {5'h00, nxt_ctrl[lst_pkg::CTRL_CLK_LO +: 2], 1'b1};
    end else if (stop) begin
      bc_req_ff  <= 1'b1;
      bc_data_ff <= {5'h00, clk_sel_ff, 1'b0};
    end else if (bc_ack_i) begin
      bc_req_ff  <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pass levels and pin routing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pass_ff    <= '0;
      gpio_ff    <= 4'h0;
      gpio_oe_ff <= 4'h0;
    end else begin
      pass_ff <= {PORTS{active}} & rx_lock_i & ~err;
      for (int i = 0; i < 4; i++) begin
        gpio_oe_ff[i] <= pin_ff[i][lst_pkg::PIN_PASS_BIT];
        gpio_ff[i]    <= pass_ff[pin_ff[i][lst_pkg::PIN_PORT_LO +: 2]];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data and acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      loc_rdata_ff <= 8'h00;
      cc_rdata_ff  <= 8'h00;
      loc_ack_ff   <= 1'b0;
      cc_ack_ff    <= 1'b0;
    end else begin
      loc_ack_ff <= loc_take;
      cc_ack_ff  <= cc_take;
      if (loc_take) begin
        loc_rdata_ff <= rd_mux(loc_addr_i);
      end
      if (cc_take) begin
        cc_rdata_ff <= rd_mux(cc_addr_i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drive
  assign loc_rdata_o       = loc_rdata_ff;
  assign cc_rdata_o        = cc_rdata_ff;
  assign loc_ack_o         = loc_ack_ff;
  assign cc_ack_o          = cc_ack_ff;
  assign bc_req_o          = bc_req_ff;
  assign bc_addr_o         = lst_pkg::REMOTE_CFG_ADDR;
  assign bc_data_o         = bc_data_ff;
  assign gpio_pass_o       = gpio_ff;
  assign gpio_pass_oe_o    = gpio_oe_ff;
  assign outputs_enable_o  = !active || gate_on;
  assign csi_lp11_idle_o   = !active || !gate_on || !pgen_run_i;
  assign pgen_allow_o      = !active || gate_on;
  assign selftest_active_o = active;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  start_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> bc_req_o && bc_data_o[0] && bc_addr_o == 8'h14)
    else $error("start did not request remote write");
  clk_fwd_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> bc_data_o[2:1] == $past(wr_data[2:1]))
    else $error("clock select not forwarded");
  clk_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    active && !start && !$past(start) |-> $stable(clk_sel_ff))
    else $error("clock select changed while running");
  gate_off_a: assert property (@(posedge clk_i) disable iff (rst_i)
    active && gating != 2'h2 |-> !outputs_enable_o && csi_lp11_idle_o)
    else $error("outputs not gated off");
  pass_low_a: assert property (@(posedge clk_i) disable iff (rst_i)
    err[0] |=> !pass_ff[0])
    else $error("pass not dropped on error");
  en_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_en && wr_addr == 8'hB3 |=> active == $past(wr_data[0]))
    else $error("enable write not applied");
  ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
    loc_req_i && !loc_ack_o |=> loc_ack_o)
    else $error("local access not acknowledged");
  debug_bit_a: assert property (@(posedge clk_i) disable iff (rst_i)
    loc_take && loc_addr_i == 8'hD0
    |=> loc_rdata_o[5] == $past(remote_selftest_active_i[rd_port]))
    else $error("debug bit does not show remote state");
endmodule : lst_selftest_ctrl
`default_nettype wire

/* verilog/lst_pkg.sv */
// Package of offsets, fields, reset values and codes for the link self-test
`default_nettype none
package lst_pkg;
  // Register offsets
  localparam logic [7:0] PAGE_SEL_ADDR   = 8'h4C; // Port page select
  localparam logic [7:0] CTRL_ADDR       = 8'hB3; // Self-test control
  localparam logic [7:0] DEBUG_ADDR      = 8'hD0; // Paged debug status
  localparam logic [7:0] TALLY_ADDR      = 8'h57; // Paged error tally
  localparam logic [7:0] PIN_CTL_ADDR    = 8'h10; // First pin function control
  localparam int         NUM_PINS        = 4;     // Pin control registers
  // Control register fields
  localparam int         CTRL_EN_BIT     = 0;     // Self-test enable
  localparam int         CTRL_CLK_LO     = 1;     // Clock select low bit
  localparam int         CTRL_GATE_LO    = 6;     // Output gating low bit
  localparam logic [1:0] GATE_ENABLED    = 2'h2;  // Outputs on during test
  // Page select fields
  localparam int         PAGE_RD_LO      = 4;     // Read port code low bit
  // Debug register field
  localparam int         DEBUG_RACT_BIT  = 5;     // Remote self-test active
  // Pin control fields
  localparam int         PIN_PASS_BIT    = 0;     // Route pass indication
  localparam int         PIN_PORT_LO     = 4;     // Port select low bit
  // Reset values
  localparam logic [7:0] PAGE_SEL_RST    = 8'h01; // Read port 0, write port 0
  localparam logic [7:0] CTRL_RST        = 8'h00; // Self-test off
  localparam logic [7:0] PIN_CTL_RST     = 8'h00; // No routing
  // Error tally codes
  localparam logic [7:0] TALLY_LOCKFAIL  = 8'hFF; // Lock never held or lost
  localparam logic [7:0] TALLY_MAX       = 8'hFE; // Largest locked count
  // Remote serializer write
  localparam logic [7:0] REMOTE_CFG_ADDR = 8'h14; // Remote test config reg
endpackage : lst_pkg
`default_nettype wire

/* verilog/lst_port_check.sv */
// Per-port pattern checker with saturating error tally
`default_nettype none
module lst_port_check #(
  parameter int W = 8                           // Received word width
) (
  input  wire logic         clk_i,              // System clock
  input  wire logic         rst_i,              // Sync reset, active high
  input  wire logic         start_i,            // Self-test start pulse
  input  wire logic         active_i,           // Self-test running
  input  wire logic         lock_i,             // Receiver lock
  input  wire logic         valid_i,            // Word strobe
  input  wire logic [W-1:0] word_i,             // Received word
  output logic              err_o,              // Mismatch this cycle
  output logic        [7:0] tally_o             // Error tally, registered
);
  ////////////////////////////////////////////////////////////////////////
  // Self-synchronising PRBS7 check, x^7 + x^6 + 1, MSB first
  function automatic logic [W+6:0] prbs_chk(input logic [6:0] h,
                                           input logic [W-1:0] w);
    logic [6:0] hist;
    logic       bad;
    hist = h;
    bad  = 1'b0;
    for (int i = W - 1; i >= 0; i--) begin
      if (w[i] != (hist[6] ^ hist[5])) begin
        bad = 1'b1;
      end
      hist = {hist[5:0], w[i]};
    end
    return {bad, {(W - 1){1'b0}}, hist};        // Flag lands on bit W+6
  endfunction : prbs_chk

  logic [6:0]   hist_ff;                        // Last seven received bits
  logic         seeded_ff;                      // History holds real data
  logic         lockfail_ff;                    // Lock missing during test
  logic [7:0]   count_ff;                       // Locked error count
  logic [W+6:0] chk;                            // Checker result
  wire          mismatch;                       // Word disagrees
  wire  [7:0]   nxt_count;                      // Saturating increment

  assign chk       = prbs_chk(hist_ff, word_i);
  assign mismatch  = active_i & lock_i & valid_i & seeded_ff & chk[W+6];
  assign err_o     = mismatch;
  assign nxt_count = (count_ff == lst_pkg::TALLY_MAX) ? count_ff
                   : count_ff + 8'h01;
  assign tally_o   = lockfail_ff ? lst_pkg::TALLY_LOCKFAIL
                   : count_ff;

  ////////////////////////////////////////////////////////////////////////
  // Pattern history and seeding
  always_ff @(posedge clk_i) begin
    if (rst_i || start_i) begin
      hist_ff   <= 7'h00;
      seeded_ff <= 1'b0;
    end else if (active_i && lock_i && valid_i) begin
      hist_ff   <= chk[6:0];
      seeded_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Tally: cleared at start, saturates, lock loss overrides
  always_ff @(posedge clk_i) begin
    if (rst_i || start_i) begin
      count_ff    <= 8'h00;
      lockfail_ff <= 1'b0;
    end else begin
      if (active_i && !lock_i) begin
        lockfail_ff <= 1'b1;
      end
      if (mismatch) begin
        count_ff <= nxt_count;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  tally_cap_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !lockfail_ff |-> count_ff <= lst_pkg::TALLY_MAX)
    else $error("locked tally above limit");
  lock_code_a: assert property (@(posedge clk_i) disable iff (rst_i)
    active_i && !lock_i && !start_i |=> tally_o == lst_pkg::TALLY_LOCKFAIL)
    else $error("lock loss not coded");
  err_count_a: assert property (@(posedge clk_i) disable iff (rst_i)
    mismatch && !start_i && count_ff < lst_pkg::TALLY_MAX
    |=> count_ff == $past(count_ff) + 8'h01)
    else $error("error not counted");
  start_clr_a: assert property (@(posedge clk_i) disable iff (rst_i)
    start_i |=> count_ff == 8'h00 && !lockfail_ff)
    else $error("tally not cleared at start");
endmodule : lst_port_check
`default_nettype wire

/* sim/lst_remote_model.sv */
// Remote serializer model: back-channel config and test pattern source
`default_nettype none
module lst_remote_model (
  input  wire logic        clk_i,       // System clock
  input  wire logic        rst_i,       // Sync reset
  input  wire logic        bc_req_i,    // Remote write pending
  input  wire logic [7:0]  bc_addr_i,   // Remote offset
  input  wire logic [7:0]  bc_data_i,   // Remote data
  input  wire logic        slow_i,      // Late acknowledge
  input  wire logic [3:0]  flip_i,      // Corrupt word MSB per port
  input  wire logic [3:0]  lock_drop_i, // Force lock loss per port
  output logic             bc_ack_o,    // Write taken
  output logic [3:0]       active_o,    // Remote test mode
  output logic [31:0]      rx_word_o,   // Words to receive ports
  output logic [3:0]       rx_valid_o,  // Word strobes
  output logic [3:0]       rx_lock_o    // Lock levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] hist_ff;                  // Pattern history, [0] newest
  logic [3:0] wait_ff;                  // Acknowledge delay count
  logic [1:0] clk_sel_ff;               // Pattern clock choice
  logic [7:0] word;                     // Next pattern word
  logic [6:0] h;                        // Scratch history
  //////////////////////////////////////////////////////////////////////
  // Pattern x^7+x^6+1, MSB first; runs always so idle words change
  always_comb begin
    h = hist_ff;
    for (int i = 0; i < 8; i++) begin
      word[7-i] = h[5] ^ h[6];
      h = {h[5:0], word[7-i]};
    end
    for (int p = 0; p < 4; p++) begin
      rx_word_o[p*8+:8] = word ^ {flip_i[p], 7'h00};
    end
  end
  assign rx_valid_o = active_o;
  assign rx_lock_o  = ~lock_drop_i;
  //////////////////////////////////////////////////////////////////////
  // Back-channel writes: acknowledge after a short or long wait
  always_ff @(posedge clk_i) begin
    hist_ff  <= rst_i ? 7'h7F : h;
    bc_ack_o <= 1'b0;
    if (rst_i) begin
      wait_ff    <= 4'h0;
      active_o   <= 4'h0;
      clk_sel_ff <= 2'h0;
    end else if (bc_req_i && !bc_ack_o) begin
      if (wait_ff >= (slow_i ? 4'h5 : 4'h0)) begin
        bc_ack_o <= 1'b1;
        wait_ff  <= 4'h0;
        if (bc_addr_i == lst_pkg::REMOTE_CFG_ADDR) begin
          active_o   <= {4{bc_data_i[0]}};
          clk_sel_ff <= bc_data_i[2:1];
        end
      end else begin
        wait_ff <= wait_ff + 4'h1;
      end
    end
  end
endmodule : lst_remote_model
`default_nettype wire

/* sim/test_link_selftest_control.sv */
// Self-checking bench for the link self-test control block
`default_nettype none
module test_link_selftest_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_i = 0, rst_i = 1;
  logic loc_req_i = 0, loc_we_i = 0, cc_req_i = 0, cc_we_i = 0;
  logic [7:0] loc_addr_i = 0, loc_wdata_i = 0, cc_addr_i = 0;
  logic [7:0] cc_wdata_i = 0, loc_rdata_o, cc_rdata_o, bc_addr_o;
  logic [7:0] bc_data_o, q;
  logic loc_ack_o, cc_ack_o, bc_req_o, bc_ack_i, outputs_enable_o;
  logic csi_lp11_idle_o, pgen_allow_o, selftest_active_o;
  logic pgen_run_i = 0, slow = 0, seen;
  logic [31:0] rx_word_i;
  logic [3:0] rx_valid_i, rx_lock_i, ract, gpio_pass_o, gpio_pass_oe_o;
  logic [3:0] flip = 0, ldrop = 0;
  logic [11:0] rows [5] = '{12'h035, 12'h435, 12'h83F, 12'hC35, 12'h00E};
  int errors = 0, comparisons = 0;
  always #12.5 clk_i = ~clk_i;
  lst_selftest_ctrl u_lst_selftest_ctrl (.clk_i(clk_i), .rst_i(rst_i),
    .loc_req_i(loc_req_i), .loc_we_i(loc_we_i), .loc_addr_i(loc_addr_i),
    .loc_wdata_i(loc_wdata_i), .loc_rdata_o(loc_rdata_o),
    .loc_ack_o(loc_ack_o), .cc_req_i(cc_req_i), .cc_we_i(cc_we_i),
    .cc_addr_i(cc_addr_i), .cc_wdata_i(cc_wdata_i),
    .cc_rdata_o(cc_rdata_o), .cc_ack_o(cc_ack_o), .rx_word_i(rx_word_i),
    .rx_valid_i(rx_valid_i), .rx_lock_i(rx_lock_i),
    .remote_selftest_active_i(ract), .bc_req_o(bc_req_o),
    .bc_addr_o(bc_addr_o), .bc_data_o(bc_data_o), .bc_ack_i(bc_ack_i),
    .gpio_pass_o(gpio_pass_o), .gpio_pass_oe_o(gpio_pass_oe_o),
    .outputs_enable_o(outputs_enable_o), .csi_lp11_idle_o(csi_lp11_idle_o),
    .pgen_allow_o(pgen_allow_o), .pgen_run_i(pgen_run_i),
    .selftest_active_o(selftest_active_o));
  lst_remote_model u_lst_remote_model (.clk_i(clk_i), .rst_i(rst_i),
    .bc_req_i(bc_req_o), .bc_addr_i(bc_addr_o), .bc_data_i(bc_data_o),
    .slow_i(slow), .flip_i(flip), .lock_drop_i(ldrop), .bc_ack_o(bc_ack_i),
    .active_o(ract), .rx_word_o(rx_word_i), .rx_valid_o(rx_valid_i),
    .rx_lock_o(rx_lock_i));
  //////////////////////////////////////////////////////////////////////
  // Print counts and verdict, end the run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test
  // Compare one value
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One register access on the local (cc=0) or channel (cc=1) path
  task automatic acc(input logic cc, we, input logic [7:0] a, d);
    int n;
    @(posedge clk_i);
    if (cc) begin
      cc_req_i   <= 1;
      cc_we_i    <= we;
      cc_addr_i  <= a;
      cc_wdata_i <= d;
    end else begin
      loc_req_i   <= 1;
      loc_we_i    <= we;
      loc_addr_i  <= a;
      loc_wdata_i <= d;
    end
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while ((cc ? cc_ack_o : loc_ack_o) !== 1'b1 && n < 20);
    q = cc ? cc_rdata_o : loc_rdata_o;
    cc_req_i <= 0;
    loc_req_i <= 0;
    if (n >= 20) chk("ack", 8'h01, 8'h00);
  endtask : acc
  // Read a tally of the chosen port
  task automatic tally(input logic [7:0] pg, e);
    acc(0, 1, 8'h4C, pg);
    acc(0, 0, 8'h57, 0);
    chk("tally", e, q);
  endtask : tally
  // Watchdog
  initial begin
    #(20000 * 25);
    errors++;
    stop_test();
  end
  //////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 0;
    acc(0, 0, 8'h4C, 0);
    chk("page_rst", 8'h01, q);
    acc(0, 0, 8'hB3, 0);
    chk("ctrl_rst", 8'h00, q);
    acc(0, 0, 8'h10, 0);
    chk("pin_rst", 8'h00, q);
    acc(0, 0, 8'h80, 0);
    chk("unmapped", 8'h00, q);
    acc(1, 1, 8'h10, 8'h01);
    acc(1, 0, 8'hB3, 0);
    chk("cc_ctrl", 8'h00, q);
    acc(0, 0, 8'h10, 0);
    chk("pin_ctl", 8'h01, q);
    // Gating and start/stop table
    foreach (rows[i]) begin
      acc(0, 1, 8'hB3, rows[i][11:4]);
      repeat (10) @(posedge clk_i);
      chk("oe", {7'h0, rows[i][3]}, {7'h0, outputs_enable_o});
      chk("lp11", {7'h0, rows[i][2]}, {7'h0, csi_lp11_idle_o});
      chk("pgen", {7'h0, rows[i][1]}, {7'h0, pgen_allow_o});
      chk("act", {7'h0, rows[i][0]}, {7'h0, selftest_active_o});
    end
    // Start with a slow remote; check the forwarded write
    slow <= 1;
    acc(0, 1, 8'hB3, 8'h83);
    chk("bc_req", 8'h01, {7'h0, bc_req_o});
    chk("bc_addr", 8'h14, bc_addr_o);
    chk("bc_data", 8'h03, bc_data_o);
    repeat (12) @(posedge clk_i);
    acc(0, 0, 8'hD0, 0);
    chk("remote_act", 8'h20, q & 8'h20);
    chk("pass_oe", 8'h01, {7'h0, gpio_pass_oe_o[0]});
    chk("pass", 8'h01, {7'h0, gpio_pass_o[0]});
    // Pattern generator started: CSI-2 leaves LP11
    pgen_run_i <= 1;
    @(posedge clk_i);
    chk("lp11_run", 8'h00, {7'h0, csi_lp11_idle_o});
    chk("pgen_run", 8'h01, {7'h0, pgen_allow_o});
    pgen_run_i <= 0;
    // Clock choice changed mid-run: no remote write
    acc(0, 1, 8'hB3, 8'h87);
    repeat (3) @(posedge clk_i);
    chk("no_bc", 8'h00, {7'h0, bc_req_o});
    chk("rem_clk", 8'h01, {6'h0, u_lst_remote_model.clk_sel_ff});
    // One corrupted word on port 0
    flip <= 4'h1;
    @(posedge clk_i);
    flip <= 4'h0;
    seen = 0;
    repeat (8) begin
      @(posedge clk_i);
      if (gpio_pass_o[0] === 1'b0) seen = 1;
    end
    chk("pass_low", 8'h01, {7'h0, seen});
    tally(8'h01, 8'h01);
    acc(0, 1, 8'h57, 8'h55);
    tally(8'h01, 8'h01);
    tally(8'h11, 8'h00);
    // Long error burst saturates
    flip <= 4'h1;
    repeat (300) @(posedge clk_i);
    flip <= 4'h0;
    tally(8'h01, 8'hFE);
    // Lock lost on port 1, watched on pin 1
    acc(0, 1, 8'h11, 8'h11);
    ldrop <= 4'h2;
    @(posedge clk_i);
    ldrop <= 4'h0;
    repeat (2) @(posedge clk_i);
    chk("lock_pin", 8'h00, {7'h0, gpio_pass_o[1]});
    tally(8'h21 - 8'h10, 8'hFF);
    // Reset in mid-run clears control and tallies
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    chk("act_rst", 8'h00, {7'h0, selftest_active_o});
    tally(8'h11, 8'h00);
    // Disable write with self-test already off after reset, then start; tallies read zero
    slow <= 0;
    acc(0, 1, 8'hB3, 8'h00);
    repeat (5) @(posedge clk_i);
    acc(0, 1, 8'hB3, 8'h81);
    tally(8'h01, 8'h00);
    tally(8'h11, 8'h00);
    stop_test();
  end
endmodule : test_link_selftest_control
`default_nettype wire
